// >>> src/pmh_pkg.sv
// package: register map, status and control fields, serial timing for the parallel midi host port
package pmh_pkg;
    localparam logic register_select_data = 1'h0;
    localparam logic register_select_status = 1'h1;
    localparam int status_byte_waiting_bit = 0;
    localparam int status_rx_busy_bit = 1;
    localparam int status_overrun_bit = 2;
    localparam int status_uart_mode_bit = 7;
    localparam logic [7:0] control_enter_uart = 8'h3f;
    localparam logic [7:0] control_reset = 8'hff;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] data_reset = 8'h00;
    localparam int clock_hz = 250000000;
    localparam int midi_baud = 31250;
    localparam int bit_cycles = clock_hz / midi_baud;
    localparam int half_bit_cycles = bit_cycles / 2;
    localparam int sync_stages = 3;
endpackage

// >>> src/pmh_stream_if.sv
// interface: valid/ready byte stream between the port's own modules
`timescale 1ns/1ps
interface pmh_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// >>> src/pmh_uart_rx.sv
// module: serial midi receiver, 8n1 at the midi baud rate
`timescale 1ns/1ps
module pmh_uart_rx #(
    parameter int bit_cycles = pmh_pkg::bit_cycles
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic serial_in,
    pmh_stream_if.source out,
    output logic busy,
    output logic overrun
);
    logic [12:0] count;
    logic [12:0] next_count;
    logic [3:0] bit_index;
    logic [3:0] next_bit_index;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic active;
    logic next_active;
    logic out_valid;
    logic next_out_valid;
    logic [7:0] out_data;
    logic [7:0] next_out_data;
    logic next_overrun;

    always_comb begin
        next_count = count;
        next_bit_index = bit_index;
        next_shift = shift;
        next_active = active;
        next_out_valid = out_valid && !out.ready;
        next_out_data = out_data;
        next_overrun = 1'b0;
        if (!active) begin
            if (!serial_in) begin
                next_active = 1'b1;
                next_count = 13'(bit_cycles / 2);
                next_bit_index = 4'h0;
            end
        end else if (count != 13'h0) begin
            next_count = count - 13'h1;
        end else begin
            next_count = 13'(bit_cycles - 1);
            next_bit_index = bit_index + 4'h1;
            if (bit_index == 4'h0) begin
                // a glitch shorter than half a bit is not a start bit
                next_active = !serial_in;
            end else if (bit_index < 4'h9) begin
                next_shift = {serial_in, shift[7:1]};
            end else begin
                next_active = 1'b0;
                if (serial_in) begin
                    // the receiver cannot wait: a full buffer loses the byte and says so
                    if (next_out_valid) begin
                        next_overrun = 1'b1;
                    end else begin
                        next_out_valid = 1'b1;
                        next_out_data = shift;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count <= 13'h0;
            bit_index <= 4'h0;
            shift <= 8'h00;
            active <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 8'h00;
            overrun <= 1'b0;
        end else begin
            count <= next_count;
            bit_index <= next_bit_index;
            shift <= next_shift;
            active <= next_active;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
            overrun <= next_overrun;
        end
    end

    assign out.valid = out_valid;
    assign out.data = out_data;
    assign busy = active;
endmodule

// >>> src/pmh_buffer.sv
// module: two-entry valid/ready buffer for received bytes
`timescale 1ns/1ps
module pmh_buffer (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    pmh_stream_if.sink in,
    pmh_stream_if.source out
);
    logic [7:0] slot [2];
    logic [7:0] next_slot [2];
    logic [1:0] fill;
    logic [1:0] next_fill;
    logic do_push;
    logic do_pop;

    always_comb begin
        do_push = in.valid && (fill != 2'h2);
        do_pop = (fill != 2'h0) && out.ready;
        next_slot = slot;
        next_fill = fill;
        if (do_pop) begin
            next_slot[0] = slot[1];
        end
        if (do_push) begin
            next_slot[(fill - 2'(do_pop)) == 2'h0 ? 0 : 1] = in.data;
        end
        next_fill = fill + 2'(do_push) - 2'(do_pop);
        if (flush) begin
            next_fill = 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            slot[0] <= 8'h00;
            slot[1] <= 8'h00;
            fill <= 2'h0;
        end else begin
            slot <= next_slot;
            fill <= next_fill;
        end
    end

    assign in.ready = (fill != 2'h2);
    assign out.valid = (fill != 2'h0);
    assign out.data = slot[0];
endmodule

// >>> src/pmh_host_port.sv
// module: parallel midi host port with serial receiver and uart pass-through
// Summary of operation
// - register_select 0 picks data; 1 picks status on read, control on write.
// - chip select and read strobe low drive data or status onto host_bus.
// - read strobe rising edge acknowledges the presented data byte.
// - write strobe rising edge commits the byte host_bus held while the strobe was low, as a host command or control.
// - interrupt output rises when a received midi byte awaits the host.
// - host reading the byte clears the interrupt after the read completes.
// - after reset serial midi bytes go to the internal synthesizer.
// - in uart mode serial midi bytes go to the host data register.
// - host_bus is 8-bit bidirectional, governed only by select and strobes.
// - strobes are ignored unless chip select is low.
`timescale 1ns/1ps
module pmh_host_port #(
    // serial bit time in clocks; the serial rate is a board choice, so it stays overridable
    parameter int bit_cycles = pmh_pkg::bit_cycles
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic register_select,
    input wire logic [7:0] host_bus_in,
    output logic [7:0] host_bus_out,
    output logic host_bus_oe,
    output logic byte_irq,
    input wire logic serial_midi_input,
    output logic synth_valid,
    output logic [7:0] synth_data,
    input wire logic synth_ready,
    output logic host_cmd_valid,
    output logic [7:0] host_cmd_data,
    output logic [7:0] control_value
);
    // every select, strobe and midi pin passes three flops; a level counts once stages two and three agree
    logic [2:0] sync_cs;
    logic [2:0] sync_rd;
    logic [2:0] sync_wr;
    logic [2:0] sync_a0;
    logic [2:0] sync_midi;
    // the bus has two flops only: it is taken while the strobe is known low, never alone
    logic [7:0] bus_s1;
    logic [7:0] bus_s2;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic a0;
    logic midi;
    logic next_cs_n;
    logic next_rd_n;
    logic next_wr_n;
    logic next_a0;
    logic next_midi;

    function automatic logic settle(input logic [2:0] s, input logic held);
        settle = (s[1] == s[2]) ? s[2] : held;
    endfunction

    always_comb begin
        next_cs_n = settle(sync_cs, cs_n);
        next_rd_n = settle(sync_rd, rd_n);
        next_wr_n = settle(sync_wr, wr_n);
        next_a0 = settle(sync_a0, a0);
        next_midi = settle(sync_midi, midi);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_cs <= 3'h7;
            sync_rd <= 3'h7;
            sync_wr <= 3'h7;
            sync_a0 <= 3'h0;
            sync_midi <= 3'h7;
            bus_s1 <= 8'h00;
            bus_s2 <= 8'h00;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            a0 <= 1'b0;
            midi <= 1'b1;
        end else begin
            sync_cs <= {sync_cs[1:0], chip_select_n};
            sync_rd <= {sync_rd[1:0], read_n};
            sync_wr <= {sync_wr[1:0], write_n};
            sync_a0 <= {sync_a0[1:0], register_select};
            sync_midi <= {sync_midi[1:0], serial_midi_input};
            bus_s1 <= host_bus_in;
            bus_s2 <= bus_s1;
            cs_n <= next_cs_n;
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
            a0 <= next_a0;
            midi <= next_midi;
        end
    end

    // receiver and buffer
    pmh_stream_if rx_stream();
    pmh_stream_if buf_stream();
    logic rx_busy;
    logic rx_overrun;
    logic uart_mode;
    logic flush;

    pmh_uart_rx #(.bit_cycles(bit_cycles)) u_rx (
        .clk(clk),
        .srst(srst),
        .serial_in(midi),
        .out(rx_stream.source),
        .busy(rx_busy),
        .overrun(rx_overrun)
    );

    pmh_buffer u_buf (
        .clk(clk),
        .srst(srst),
        .flush(flush),
        .in(rx_stream.sink),
        .out(buf_stream.source)
    );

    // host strobe decoding; strobes count only while chip select is low
    logic rd_active;
    logic wr_active;
    logic rd_rise;
    logic wr_rise;
    logic rd_prev;
    logic wr_prev;
    logic [7:0] wr_byte;
    logic [7:0] next_wr_byte;
    assign rd_active = !cs_n && !rd_n;
    assign wr_active = !cs_n && !wr_n;
    assign rd_rise = rd_prev && !rd_active;
    assign wr_rise = wr_prev && !wr_active;

    // data register: holds the byte presented to the host
    logic [7:0] midi_data;
    logic [7:0] next_midi_data;
    logic byte_waiting;
    logic next_byte_waiting;
    logic [7:0] port_control;
    logic [7:0] next_port_control;
    logic next_uart_mode;
    logic overrun_flag;
    logic next_overrun_flag;
    logic [7:0] port_status;
    logic take;
    logic ack_data;
    logic [7:0] next_bus_out;
    logic next_bus_oe;
    logic next_cmd_valid;
    logic [7:0] next_cmd_data;

    always_comb begin
        port_status = pmh_pkg::status_reset;
        port_status[pmh_pkg::status_byte_waiting_bit] = byte_waiting;
        port_status[pmh_pkg::status_rx_busy_bit] = rx_busy;
        port_status[pmh_pkg::status_overrun_bit] = overrun_flag;
        port_status[pmh_pkg::status_uart_mode_bit] = uart_mode;
    end

    always_comb begin
        // a read of data in progress freezes the byte so the host sees a stable value
        ack_data = rd_rise && (a0 == pmh_pkg::register_select_data);
        take = uart_mode && buf_stream.valid && (!byte_waiting || ack_data) && !rd_active;
        next_midi_data = midi_data;
        next_byte_waiting = byte_waiting;
        if (ack_data) begin
            next_byte_waiting = 1'b0;
        end
        if (take) begin
            next_midi_data = buf_stream.data;
            next_byte_waiting = 1'b1;
        end
        next_port_control = port_control;
        next_uart_mode = uart_mode;
        next_cmd_valid = 1'b0;
        next_cmd_data = host_cmd_data;
        flush = 1'b0;
        // the byte is caught while the write strobe is still low, in step with the bus flops,
        // because a host may take its data away as soon as the strobe rises
        next_wr_byte = wr_byte;
        if (!sync_wr[1] && !sync_cs[1]) begin
            next_wr_byte = bus_s2;
        end
        if (wr_rise) begin
            if (a0 == pmh_pkg::register_select_data) begin
                next_cmd_valid = 1'b1;
                next_cmd_data = wr_byte;
            end else begin
                next_port_control = wr_byte;
                if (wr_byte == pmh_pkg::control_enter_uart) begin
                    next_uart_mode = 1'b1;
                end else if (wr_byte == pmh_pkg::control_reset) begin
                    // interface reset returns the serial input to the synthesizer
                    next_uart_mode = 1'b0;
                    next_byte_waiting = 1'b0;
                    flush = 1'b1;
                end
            end
        end
        // overrun set wins over its clear by a status read
        next_overrun_flag = overrun_flag;
        if (rd_rise && a0 == pmh_pkg::register_select_status) begin
            next_overrun_flag = 1'b0;
        end
        if (rx_overrun) begin
            next_overrun_flag = 1'b1;
        end
        next_bus_oe = rd_active;
        next_bus_out = (a0 == pmh_pkg::register_select_data) ? midi_data : port_status;
    end

    // synthesizer path takes the buffer when not in uart mode
    assign buf_stream.ready = uart_mode ? take : synth_ready;

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
            wr_byte <= 8'h00;
            midi_data <= pmh_pkg::data_reset;
            byte_waiting <= 1'b0;
            port_control <= pmh_pkg::control_reset;
            uart_mode <= 1'b0;
            overrun_flag <= 1'b0;
            host_bus_out <= 8'h00;
            host_bus_oe <= 1'b0;
            byte_irq <= 1'b0;
            synth_valid <= 1'b0;
            synth_data <= 8'h00;
            host_cmd_valid <= 1'b0;
            host_cmd_data <= 8'h00;
            control_value <= pmh_pkg::control_reset;
        end else begin
            rd_prev <= rd_active;
            wr_prev <= wr_active;
            wr_byte <= next_wr_byte;
            midi_data <= next_midi_data;
            byte_waiting <= next_byte_waiting;
            port_control <= next_port_control;
            uart_mode <= next_uart_mode;
            overrun_flag <= next_overrun_flag;
            host_bus_out <= next_bus_out;
            host_bus_oe <= next_bus_oe;
            byte_irq <= next_byte_waiting;
            synth_valid <= !uart_mode && buf_stream.valid && synth_ready;
            synth_data <= buf_stream.data;
            host_cmd_valid <= next_cmd_valid;
            host_cmd_data <= next_cmd_data;
            control_value <= next_port_control;
        end
    end

    // multi-step behaviours are built from these
    sequence s_data_write;
        wr_rise && (a0 == pmh_pkg::register_select_data);
    endsequence

    sequence s_data_read_done;
        ack_data && !take;
    endsequence

    sequence s_byte_arrives;
        take && !byte_waiting;
    endsequence

    // bus direction and presented value
    a_bus_released: assert property (@(posedge clk) disable iff (srst)
        (cs_n || rd_n) |=> !host_bus_oe) else $error("host bus driven outside a read");
    a_bus_driven: assert property (@(posedge clk) disable iff (srst)
        (!cs_n && !rd_n) |=> host_bus_oe) else $error("host bus not driven during a read");
    a_status_sel: assert property (@(posedge clk) disable iff (srst)
        (rd_active && a0) |=> host_bus_out == $past(port_status)) else $error("status not presented");
    a_data_presented: assert property (@(posedge clk) disable iff (srst)
        (rd_active && a0 == pmh_pkg::register_select_data) |=> host_bus_out == $past(midi_data))
        else $error("data register not presented");
    a_read_freeze: assert property (@(posedge clk) disable iff (srst)
        rd_active |=> $stable(midi_data)) else $error("data register changed during a read");

    // interrupt and status flag
    a_irq_matches: assert property (@(posedge clk) disable iff (srst)
        (rd_active && a0) |=> host_bus_out[pmh_pkg::status_byte_waiting_bit] == $past(byte_irq))
        else $error("interrupt and status flag differ");
    a_irq_clear: assert property (@(posedge clk) disable iff (srst)
        s_data_read_done |=> !byte_irq) else $error("interrupt not cleared by data read");
    a_irq_rise: assert property (@(posedge clk) disable iff (srst)
        s_byte_arrives |=> byte_irq && byte_waiting) else $error("interrupt missing for byte");

    // writes and routing
    a_no_write_cs: assert property (@(posedge clk) disable iff (srst)
        (cs_n && !$past(wr_active)) |=> !host_cmd_valid) else $error("write taken without chip select");
    a_cmd_pulse: assert property (@(posedge clk) disable iff (srst)
        s_data_write |=> (host_cmd_valid && host_cmd_data == $past(wr_byte)) ##1 !host_cmd_valid)
        else $error("data write did not give one command pulse");
    a_synth_route: assert property (@(posedge clk) disable iff (srst)
        !uart_mode |-> !take) else $error("byte sent to host outside uart mode");
    a_uart_route: assert property (@(posedge clk) disable iff (srst)
        uart_mode |=> !synth_valid) else $error("byte sent to synth in uart mode");
    a_ctrl_write: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && a0) |=> control_value == $past(wr_byte)) else $error("control write lost");
    a_iface_reset: assert property (@(posedge clk) disable iff (srst)
        (wr_rise && a0 == pmh_pkg::register_select_status && wr_byte == pmh_pkg::control_reset)
        |=> (!uart_mode && !byte_irq)) else $error("interface reset did not restore synth routing");
endmodule

// >>> testbench/pmh_host_model.sv
// host processor model: drives the parallel port pins and resolves the shared data bus
`timescale 1ns/1ps
module pmh_host_model (
    input wire logic clk,
    input wire logic [7:0] host_bus_out,
    input wire logic host_bus_oe,
    output logic chip_select_n,
    output logic read_n,
    output logic write_n,
    output logic register_select,
    output logic [7:0] host_bus_in,
    output logic rd_done,
    output logic [7:0] rd_data
);
    logic [7:0] drv;
    logic drv_en;
    logic [7:0] last = 8'h00;

    // no pull on the data lines: a released bus shows a changing pattern, never a stale byte
    always_comb begin
        if (host_bus_oe) begin
            host_bus_in = host_bus_out;
        end else if (drv_en) begin
            host_bus_in = drv;
        end else begin
            host_bus_in = ~last;
        end
    end

    always_ff @(posedge clk) begin
        last <= host_bus_in;
    end

    initial begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        register_select = 1'b0;
        drv = 8'h00;
        drv_en = 1'b0;
        rd_done = 1'b0;
        rd_data = 8'h00;
    end

    // strobes stay low 10 cycles and high well over 6, since the pins pass a 3-flop synchroniser
    task access(input logic rs, input logic wr, input logic cs_n, input logic [7:0] d);
        @(posedge clk);
        #1;
        register_select = rs;
        chip_select_n = cs_n;
        drv = d;
        drv_en = wr;
        repeat (2) @(posedge clk);
        #1;
        if (wr) begin
            write_n = 1'b0;
        end else begin
            read_n = 1'b0;
        end
        repeat (10) @(posedge clk);
        rd_data = host_bus_in;
        #1;
        write_n = 1'b1;
        read_n = 1'b1;
        rd_done = ~wr;
        @(posedge clk);
        #1;
        rd_done = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chip_select_n = 1'b1;
        drv_en = 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// >>> testbench/tb_parallel_midi_host_port.sv
// testbench: register access, serial routing to synthesizer and uart read path
`timescale 1ns/1ps
module tb_parallel_midi_host_port;
    logic clk;
    logic srst;
    logic chip_select_n;
    logic read_n;
    logic write_n;
    logic register_select;
    logic [7:0] host_bus_in;
    logic [7:0] host_bus_out;
    logic host_bus_oe;
    logic byte_irq;
    logic serial_midi_input;
    logic synth_valid;
    logic [7:0] synth_data;
    logic synth_ready;
    logic host_cmd_valid;
    logic [7:0] host_cmd_data;
    logic [7:0] control_value;
    logic rd_done;
    logic [7:0] rd_data;
    logic [7:0] b;
    logic [9:0] notes[$];
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    // a short bit time keeps each serial frame to a few hundred clocks
    localparam int tb_bit_cycles = 64;

    pmh_host_port #(.bit_cycles(tb_bit_cycles)) u_pmh_host_port (.clk(clk), .srst(srst),
        .chip_select_n(chip_select_n), .read_n(read_n),
        .write_n(write_n), .register_select(register_select), .host_bus_in(host_bus_in),
        .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .byte_irq(byte_irq),
        .serial_midi_input(serial_midi_input), .synth_valid(synth_valid), .synth_data(synth_data),
        .synth_ready(synth_ready), .host_cmd_valid(host_cmd_valid), .host_cmd_data(host_cmd_data),
        .control_value(control_value));

    pmh_host_model u_pmh_host_model (.clk(clk), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
        .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
        .register_select(register_select), .host_bus_in(host_bus_in), .rd_done(rd_done), .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task end_of_test;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task expect_eq(input logic [9:0] got, input logic [9:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task take(input logic [1:0] k, input logic [7:0] d);
        if (notes.size() == 0) begin
            failures++;
            $display("MISMATCH t=%0t unexpected output kind %0d", $time, k);
        end else begin
            expect_eq({k, d}, notes.pop_front(), "output byte");
        end
    endtask

    // kind 0 synthesizer byte, 1 host command byte, 2 host read result
    always @(posedge clk) begin
        if (!srst) begin
            if (synth_valid) take(2'd0, synth_data);
            if (host_cmd_valid) take(2'd1, host_cmd_data);
            if (rd_done) take(2'd2, rd_data);
        end
    end

    // synthesizer stalls at random; the two-entry buffer must hold the byte meanwhile
    always @(posedge clk) begin
        #1;
        if (!srst) synth_ready = ($urandom_range(3) != 0);
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("MISMATCH t=%0t timeout", $time);
            end_of_test;
        end
    end

    task send_midi(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            serial_midi_input = f[i];
            repeat (tb_bit_cycles - 1) @(posedge clk);
        end
    endtask

    task drain;
        for (int i = 0; i < 300 && notes.size() != 0; i++) @(posedge clk);
        expect_eq(10'(notes.size()), 10'h000, "outputs still pending");
    endtask

    initial begin
        srst = 1'b1;
        serial_midi_input = 1'b1;
        synth_ready = 1'b1;
        b = 8'($urandom(85151));
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        expect_eq({2'h0, control_value}, 10'h0ff, "control after reset");
        expect_eq({9'h000, host_bus_oe}, 10'h000, "bus not released");
        notes.push_back({2'd2, pmh_pkg::status_reset});
        u_pmh_host_model.access(1'b1, 1'b0, 1'b0, 8'h00);
        u_pmh_host_model.access(1'b1, 1'b1, 1'b1, pmh_pkg::control_enter_uart);
        expect_eq({2'h0, control_value}, 10'h0ff, "deselected write taken");
        b = 8'($urandom);
        notes.push_back({2'd1, b});
        u_pmh_host_model.access(1'b0, 1'b1, 1'b0, b);
        b = 8'($urandom);
        notes.push_back({2'd0, b});
        send_midi(b);
        drain();
        u_pmh_host_model.access(1'b1, 1'b1, 1'b0, pmh_pkg::control_enter_uart);
        expect_eq({2'h0, control_value}, 10'h03f, "control write");
        notes.push_back({2'd2, 8'h80});
        u_pmh_host_model.access(1'b1, 1'b0, 1'b0, 8'h00);
        expect_eq({9'h000, byte_irq}, 10'h000, "irq before byte");
        b = 8'($urandom);
        send_midi(b);
        expect_eq({9'h000, byte_irq}, 10'h001, "irq after byte");
        notes.push_back({2'd2, 8'h81});
        u_pmh_host_model.access(1'b1, 1'b0, 1'b0, 8'h00);
        notes.push_back({2'd2, b});
        u_pmh_host_model.access(1'b0, 1'b0, 1'b0, 8'h00);
        expect_eq({9'h000, byte_irq}, 10'h000, "irq after read");
        expect_eq({9'h000, host_bus_oe}, 10'h000, "bus not released");
        notes.push_back({2'd2, 8'h80});
        u_pmh_host_model.access(1'b1, 1'b0, 1'b0, 8'h00);
        u_pmh_host_model.access(1'b1, 1'b1, 1'b0, pmh_pkg::control_reset);
        expect_eq({2'h0, control_value}, 10'h0ff, "interface reset");
        notes.push_back({2'd2, 8'h00});
        u_pmh_host_model.access(1'b1, 1'b0, 1'b0, 8'h00);
        drain();
        end_of_test;
    end
endmodule
